// ==== design/mhc_pkg.sv ====
// Constants, carriers and register map of the monitor host control block.
// Assumes one 25 MHz clock; host bus, serial bus and VID pins arrive asynchronously.
// Summary of operation
// - Write index port, then access data port
// - Index register keeps last written value except where parallel data accesses auto-increment it
// - Serial write: address, pointer, one data byte
// - Serial read returns byte at pointer, repeated while master acks
// - Serial accesses never auto-increment the pointer
// - Slave address resets to 0101101, writable
// - Index bit 7 shows serial busy
// - Value and POST memories have no reset
// - Power-on: converter stopped, interrupt clear asserted
// - Config bit 7 soft-initialises, then self-clears
// - Slave address untouched by soft init
// - Chip reset bit 5 forces full reset
// - Both strobes low, CS high: full reset
// - Config bit 0 starts or halts monitoring
// - Config bits 1 and 2 enable interrupts
// - Config bit 5 selects selIrqOut polarity; mgmtIrqOutN stays active low
// - Bypass bit drives open-drain output low
// - Monitoring runs with start high, clear low
// - Round: temperature, five, two, three fans
// - Result read restarts the current conversion
// - Ports 0 and 4 POST, 5 index, 6 data
// - Upper value region auto-increments, stops at top
package mhc_pkg;
  localparam int CLK_KHZ      = 25000;
  localparam int STRB_RST_NS  = 50;
  localparam int STRB_RST_CYC = (STRB_RST_NS * CLK_KHZ + 999999) / 1000000;
  localparam int ROUND_MS     = 1000;
  localparam int ROUND_CYC    = ROUND_MS * CLK_KHZ;
  localparam int NUM_ITEMS    = 11;

  localparam logic [2:0] PORT_POST0 = 3'h0;
  localparam logic [2:0] PORT_POST4 = 3'h4;
  localparam logic [2:0] PORT_INDEX = 3'h5;
  localparam logic [2:0] PORT_DATA  = 3'h6;

  localparam logic [6:0] A_CFG      = 7'h40;
  localparam logic [6:0] A_ISR1     = 7'h41;
  localparam logic [6:0] A_ISR2     = 7'h42;
  localparam logic [6:0] A_SMI1     = 7'h43;
  localparam logic [6:0] A_SMI2     = 7'h44;
  localparam logic [6:0] A_NMI1     = 7'h45;
  localparam logic [6:0] A_NMI2     = 7'h46;
  localparam logic [6:0] A_FANDIV   = 7'h47;
  localparam logic [6:0] A_SADDR    = 7'h48;
  localparam logic [6:0] A_CHIPID   = 7'h49;
  localparam logic [6:0] A_POST_TOP = 7'h1f;
  localparam logic [6:0] A_VAL_TOP  = 7'h7f;
  localparam logic [6:0] A_RES_LO   = 7'h20;
  localparam logic [6:0] A_RES_HI   = 7'h2a;
  localparam logic [5:0] VAL_RES_IDX = 6'h00;

  localparam logic [7:0] CFG_RST    = 8'h08;
  localparam logic [7:0] ZERO_RST   = 8'h00;
  localparam logic [7:0] NMI2_RST   = 8'h40;
  localparam logic [3:0] FANDIV_RST = 4'h5;
  localparam logic [6:0] SADDR_RST  = 7'h2d;

  localparam int CFG_START   = 0;
  localparam int CFG_SMI_EN  = 1;
  localparam int CFG_NMI_EN  = 2;
  localparam int CFG_INT_CLR = 3;
  localparam int CFG_NMI_POL = 5;
  localparam int CFG_BYPASS  = 6;
  localparam int CFG_INIT    = 7;
  localparam int CHIP_RST    = 5;

  typedef struct packed {
    logic       csN;
    logic       rdN;
    logic       wrN;
    logic [2:0] addr;
    logic [7:0] data;
  } mhc_isa_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } mhc_ser_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_PTR = 3'b010, S_WDATA = 3'b011,
    S_ACK = 3'b100, S_RDATA = 3'b101, S_MACK = 3'b110, S_SKIP = 3'b111
  } mhc_ser_state_t;

  typedef enum logic [1:0] {M_IDLE = 2'b00, M_CONV = 2'b01, M_GAP = 2'b10} mhc_mon_state_t;
endpackage : mhc_pkg

// ==== design/mhc_top.sv ====
// Host access, serial slave, configuration and monitoring sequencer of the monitor.
// Assumes host bus, serial bus and VID pins are asynchronous to ref_clk; converter handshake is on ref_clk.
`timescale 1ns/1ps
module mhc_top #(
  parameter int          ROUND_CYCLES = mhc_pkg::ROUND_CYC,
  parameter logic [1:0]  CHIP_ID_HI   = 2'h2  // Arbitrary identification value
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       isaCsN,
  input  wire logic       isaRdN,
  input  wire logic       isaWrN,
  input  wire logic [2:0] isaAddr,
  input  wire logic [7:0] isaDataIn,
  output      logic [7:0] isaDataOut,
  output      logic       isaDataOeN,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output      logic       sdaOut,
  output      logic       sdaOeN,
  input  wire logic [4:0] vidIn,
  input  wire logic [7:0] eventIn1,
  input  wire logic [7:0] eventIn2,
  input  wire logic       convDone,
  input  wire logic [7:0] convResult,
  output      logic       convStart,
  output      logic [3:0] convChannel,
  output      logic       mgmtIrqOutN,
  output      logic       selIrqOut,
  output      logic       bypassOut,
  output      logic       bypassOeN
);
  if (ROUND_CYCLES < 2) begin : g_chk_round
    $error("ROUND_CYCLES must be at least 2");
  end
  if (mhc_pkg::STRB_RST_CYC > 15) begin : g_chk_strb
    $error("strobe reset count too large");
  end
  localparam int RCW = $clog2(ROUND_CYCLES + 1);
  localparam logic [RCW-1:0] ROUND_LAST = RCW'(ROUND_CYCLES - 1);
  localparam logic [3:0] STRB_LAST = 4'(mhc_pkg::STRB_RST_CYC - 1);
  localparam logic [3:0] LAST_ITEM = 4'(mhc_pkg::NUM_ITEMS - 1);

  // Pin synchronisers; the first stage feeds only the second
  mhc_pkg::mhc_isa_t isaS1_q, isaCur, isaPrv;
  mhc_pkg::mhc_ser_t serS1_q, serCur, serPrv;
  logic [4:0] vidS1_q, vidS_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      isaS1_q <= '1;
      isaCur  <= '1;
      isaPrv  <= '1;
      serS1_q <= '1;
      serCur  <= '1;
      serPrv  <= '1;
      vidS1_q <= '0;
      vidS_q  <= '0;
    end else begin
      isaS1_q <= '{isaCsN, isaRdN, isaWrN, isaAddr, isaDataIn};
      isaCur  <= isaS1_q;
      isaPrv  <= isaCur;
      serS1_q <= '{sclIn, sdaIn};
      serCur  <= serS1_q;
      serPrv  <= serCur;
      vidS1_q <= vidIn;
      vidS_q  <= vidS1_q;
    end
  end

  mhc_pkg::mhc_ser_state_t serState_q, serNext_q;
  mhc_pkg::mhc_mon_state_t monState_q;
  logic [7:0] serShift_q;
  logic [3:0] bitCnt_q, strbCnt_q, chan_q;
  logic [6:0] idx_q, slaveAddr_q;
  logic [4:0] postPtr_q;
  logic [7:0] cfg_q, isr1_q, isr2_q, smi1_q, smi2_q, nmi1_q, nmi2_q;
  logic [3:0] fanDiv_q;
  logic       fullRst_q;
  logic [RCW-1:0] roundCnt_q;
  logic [7:0] postMem [32];
  logic [7:0] valMem  [64];

  // Parallel bus decode on the trailing edge of each strobe
  wire busy      = serState_q != mhc_pkg::S_IDLE;
  wire rdActive  = !isaCur.csN && !isaCur.rdN;
  wire isaRdEnd  = !isaPrv.csN && !isaPrv.rdN && isaCur.rdN;
  wire isaWrEnd  = !isaPrv.csN && !isaPrv.wrN && isaCur.wrN;
  wire isaIdxWr  = isaWrEnd && isaPrv.addr == mhc_pkg::PORT_INDEX && !busy;
  wire isaDatWr  = isaWrEnd && isaPrv.addr == mhc_pkg::PORT_DATA && !busy;
  wire isaDatRd  = isaRdEnd && isaPrv.addr == mhc_pkg::PORT_DATA && !busy;
  wire isaPostWr = isaWrEnd && !busy &&
                   (isaPrv.addr == mhc_pkg::PORT_POST0 || isaPrv.addr == mhc_pkg::PORT_POST4);
  wire strbLow   = isaCur.csN && !isaCur.rdN && !isaCur.wrN;

  // Serial bus conditions
  wire sclRise   = !serPrv.scl && serCur.scl;
  wire sclFall   = serPrv.scl && !serCur.scl;
  wire serStart  = serPrv.scl && serCur.scl && serPrv.sda && !serCur.sda;
  wire serStop   = serPrv.scl && serCur.scl && !serPrv.sda && serCur.sda;
  wire rxState   = serState_q == mhc_pkg::S_ADDR || serState_q == mhc_pkg::S_PTR ||
                   serState_q == mhc_pkg::S_WDATA;
  wire serByte   = rxState && sclFall && bitCnt_q == 4'h8;
  wire addrHit   = serShift_q[7:1] == slaveAddr_q;
  wire serPtrWr  = serByte && serState_q == mhc_pkg::S_PTR;
  wire serRegWr  = serByte && serState_q == mhc_pkg::S_WDATA;
  wire serLoad   = sclFall && ((serState_q == mhc_pkg::S_ACK && serNext_q == mhc_pkg::S_RDATA) ||
                   (serState_q == mhc_pkg::S_MACK && bitCnt_q == 4'h9));

  // Shared register access, addressed by the index register for both hosts
  wire       regWr     = isaDatWr || serRegWr;
  wire [7:0] regWrData = serRegWr ? serShift_q : isaPrv.data;
  wire       regRd     = isaDatRd || serLoad;
  wire       isPost    = idx_q[6:5] == 2'h0;
  wire       isVal     = idx_q[5];
  wire [5:0] valIdx    = {idx_q[6], idx_q[4:0]};
  wire       softInit  = regWr && idx_q == mhc_pkg::A_CFG && regWrData[mhc_pkg::CFG_INIT];
  wire       chipRstWr = regWr && idx_q == mhc_pkg::A_CHIPID && regWrData[mhc_pkg::CHIP_RST];
  wire       initAll   = softInit || fullRst_q;
  wire       wrCtl     = regWr && !softInit;
  wire       resultRd  = regRd && idx_q >= mhc_pkg::A_RES_LO && idx_q <= mhc_pkg::A_RES_HI;
  wire       run       = cfg_q[mhc_pkg::CFG_START] && !cfg_q[mhc_pkg::CFG_INT_CLR];
  wire       convWr    = monState_q == mhc_pkg::M_CONV && convDone && !resultRd;
  wire [5:0] resIdx    = mhc_pkg::VAL_RES_IDX + {2'h0, chan_q};

  function automatic logic [7:0] ctlRead(input logic [6:0] a);
    if (a == mhc_pkg::A_CFG) ctlRead = cfg_q;
    else if (a == mhc_pkg::A_ISR1) ctlRead = isr1_q;
    else if (a == mhc_pkg::A_ISR2) ctlRead = isr2_q;
    else if (a == mhc_pkg::A_SMI1) ctlRead = smi1_q;
    else if (a == mhc_pkg::A_SMI2) ctlRead = smi2_q;
    else if (a == mhc_pkg::A_NMI1) ctlRead = nmi1_q;
    else if (a == mhc_pkg::A_NMI2) ctlRead = nmi2_q;
    else if (a == mhc_pkg::A_FANDIV) ctlRead = {fanDiv_q, vidS_q[3:0]};
    else if (a == mhc_pkg::A_SADDR) ctlRead = {1'b0, slaveAddr_q};
    else if (a == mhc_pkg::A_CHIPID) ctlRead = {CHIP_ID_HI, 5'h00, vidS_q[4]};
    else ctlRead = 8'h00;
  endfunction : ctlRead

  // Auto-increment for parallel data-port accesses only
  function automatic logic [6:0] incIdx(input logic [6:0] a);
    if (a == mhc_pkg::A_ISR1 || a == mhc_pkg::A_SMI1 || a == mhc_pkg::A_NMI1) incIdx = a + 7'h01;
    else if (a < mhc_pkg::A_POST_TOP) incIdx = a + 7'h01;
    else if (a[6:5] == 2'h3 && a != mhc_pkg::A_VAL_TOP) incIdx = a + 7'h01;
    else incIdx = a;
  endfunction : incIdx

  wire [7:0] regRdData = isPost ? postMem[idx_q[4:0]] : isVal ? valMem[valIdx] : ctlRead(idx_q);
  wire [7:0] portRd    = isaCur.addr == mhc_pkg::PORT_INDEX ? {busy, idx_q} :
                         isaCur.addr == mhc_pkg::PORT_DATA ? regRdData : 8'h00;
  wire       smiAct    = |(isr1_q & ~smi1_q) || |(isr2_q & ~smi2_q);
  wire       nmiAct    = |(isr1_q & ~nmi1_q) || |(isr2_q & ~nmi2_q);
  wire       selAct    = cfg_q[mhc_pkg::CFG_NMI_EN] && !cfg_q[mhc_pkg::CFG_INT_CLR] && nmiAct;

  // Full reset from strobe pattern or chip reset bit
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strbCnt_q <= 4'h0;
      fullRst_q <= 1'b0;
    end else begin
      strbCnt_q <= strbLow ? (strbCnt_q == STRB_LAST ? strbCnt_q : strbCnt_q + 4'h1) : 4'h0;
      fullRst_q <= chipRstWr || (strbLow && strbCnt_q == STRB_LAST);
    end
  end

  // Index register and POST write pointer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      idx_q     <= 7'h00;
      postPtr_q <= 5'h00;
    end else if (fullRst_q) begin
      idx_q     <= 7'h00;
      postPtr_q <= 5'h00;
    end else begin
      if (serPtrWr) idx_q <= serShift_q[6:0];
      else if (isaIdxWr) idx_q <= isaPrv.data[6:0];
      else if (isaDatWr || isaDatRd) idx_q <= incIdx(idx_q);
      if (isaPostWr && postPtr_q != mhc_pkg::A_POST_TOP[4:0]) postPtr_q <= postPtr_q + 5'h01;
    end
  end

  // Control registers; soft init spares the slave address
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfg_q       <= mhc_pkg::CFG_RST;
      isr1_q      <= mhc_pkg::ZERO_RST;
      isr2_q      <= mhc_pkg::ZERO_RST;
      smi1_q      <= mhc_pkg::ZERO_RST;
      smi2_q      <= mhc_pkg::ZERO_RST;
      nmi1_q      <= mhc_pkg::ZERO_RST;
      nmi2_q      <= mhc_pkg::NMI2_RST;
      fanDiv_q    <= mhc_pkg::FANDIV_RST;
      slaveAddr_q <= mhc_pkg::SADDR_RST;
    end else begin
      if (initAll) begin
        cfg_q    <= mhc_pkg::CFG_RST;
        isr1_q   <= mhc_pkg::ZERO_RST;
        isr2_q   <= mhc_pkg::ZERO_RST;
        smi1_q   <= mhc_pkg::ZERO_RST;
        smi2_q   <= mhc_pkg::ZERO_RST;
        nmi1_q   <= mhc_pkg::ZERO_RST;
        nmi2_q   <= mhc_pkg::NMI2_RST;
        fanDiv_q <= mhc_pkg::FANDIV_RST;
      end else begin
        if (wrCtl && idx_q == mhc_pkg::A_CFG) cfg_q <= {1'b0, regWrData[6:0]};
        if (wrCtl && idx_q == mhc_pkg::A_SMI1) smi1_q <= regWrData;
        if (wrCtl && idx_q == mhc_pkg::A_SMI2) smi2_q <= regWrData;
        if (wrCtl && idx_q == mhc_pkg::A_NMI1) nmi1_q <= regWrData;
        if (wrCtl && idx_q == mhc_pkg::A_NMI2) nmi2_q <= regWrData;
        if (wrCtl && idx_q == mhc_pkg::A_FANDIV) fanDiv_q <= regWrData[7:4];
        // Clear on read, a same-cycle event still sets
        isr1_q <= ((regRd && idx_q == mhc_pkg::A_ISR1) ? 8'h00 : isr1_q) | eventIn1;
        isr2_q <= ((regRd && idx_q == mhc_pkg::A_ISR2) ? 8'h00 : isr2_q) | eventIn2;
      end
      if (fullRst_q) slaveAddr_q <= mhc_pkg::SADDR_RST;
      else if (regWr && idx_q == mhc_pkg::A_SADDR) slaveAddr_q <= regWrData[6:0];
    end
  end

  // Memories hold no reset value
  always_ff @(posedge ref_clk) begin
    if (convWr) valMem[resIdx] <= convResult;
    else if (regWr && isVal) valMem[valIdx] <= regWrData;
    if (isaPostWr) postMem[postPtr_q] <= isaPrv.data;
    else if (regWr && isPost) postMem[idx_q[4:0]] <= regWrData;
  end

  // Serial slave: one pointer byte and one data byte per write, no auto-increment
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      serState_q <= mhc_pkg::S_IDLE;
      serNext_q  <= mhc_pkg::S_IDLE;
      serShift_q <= 8'h00;
      bitCnt_q   <= 4'h0;
    end else if (fullRst_q || serStop) begin
      serState_q <= mhc_pkg::S_IDLE;
    end else if (serStart) begin
      serState_q <= mhc_pkg::S_ADDR;
      bitCnt_q   <= 4'h0;
    end else begin
      case (serState_q)
        mhc_pkg::S_ADDR, mhc_pkg::S_PTR, mhc_pkg::S_WDATA: begin
          if (sclRise) begin
            serShift_q <= {serShift_q[6:0], serCur.sda};
            bitCnt_q   <= bitCnt_q + 4'h1;
          end else if (serByte) begin
            serState_q <= (serState_q != mhc_pkg::S_ADDR || addrHit) ? mhc_pkg::S_ACK : mhc_pkg::S_SKIP;
            serNext_q  <= serState_q == mhc_pkg::S_PTR ? mhc_pkg::S_WDATA :
                          serState_q == mhc_pkg::S_WDATA ? mhc_pkg::S_SKIP :
                          serShift_q[0] ? mhc_pkg::S_RDATA : mhc_pkg::S_PTR;
          end
        end
        mhc_pkg::S_ACK: begin
          if (sclFall) begin
            serState_q <= serNext_q;
            bitCnt_q   <= 4'h0;
            if (serLoad) serShift_q <= regRdData;
          end
        end
        mhc_pkg::S_RDATA: begin
          if (sclFall) begin
            serShift_q <= {serShift_q[6:0], 1'b0};
            bitCnt_q   <= bitCnt_q + 4'h1;
            if (bitCnt_q == 4'h7) serState_q <= mhc_pkg::S_MACK;
          end
        end
        mhc_pkg::S_MACK: begin
          if (sclRise && serCur.sda) serState_q <= mhc_pkg::S_SKIP;
          else if (sclRise) bitCnt_q <= 4'h9;
          else if (serLoad) begin
            serState_q <= mhc_pkg::S_RDATA;
            serShift_q <= regRdData;
            bitCnt_q   <= 4'h0;
          end
        end
        default: serState_q <= serState_q;
      endcase
    end
  end

  // Round-robin monitoring sequencer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      monState_q <= mhc_pkg::M_IDLE;
      chan_q     <= 4'h0;
      convStart  <= 1'b0;
      roundCnt_q <= '0;
    end else if (!run || fullRst_q) begin
      monState_q <= mhc_pkg::M_IDLE;
      chan_q     <= 4'h0;
      convStart  <= 1'b0;
    end else begin
      convStart  <= 1'b0;
      roundCnt_q <= roundCnt_q == ROUND_LAST ? roundCnt_q : roundCnt_q + RCW'(1);
      case (monState_q)
        mhc_pkg::M_CONV: begin
          if (resultRd) convStart <= 1'b1;
          else if (convDone && chan_q == LAST_ITEM) monState_q <= mhc_pkg::M_GAP;
          else if (convDone) begin
            chan_q    <= chan_q + 4'h1;
            convStart <= 1'b1;
          end
        end
        mhc_pkg::M_GAP: begin
          if (roundCnt_q == ROUND_LAST) begin
            monState_q <= mhc_pkg::M_CONV;
            chan_q     <= 4'h0;
            convStart  <= 1'b1;
            roundCnt_q <= '0;
          end
        end
        default: begin
          monState_q <= mhc_pkg::M_CONV;
          chan_q     <= 4'h0;
          convStart  <= 1'b1;
          roundCnt_q <= '0;
        end
      endcase
    end
  end
  assign convChannel = chan_q;

  // Pin drivers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      isaDataOut  <= 8'h00;
      isaDataOeN  <= 1'b1;
      sdaOut      <= 1'b0;
      sdaOeN      <= 1'b1;
      mgmtIrqOutN <= 1'b1;
      selIrqOut   <= 1'b1;
      bypassOut   <= 1'b0;
      bypassOeN   <= 1'b1;
    end else begin
      isaDataOut  <= portRd;
      isaDataOeN  <= !rdActive;
      sdaOut      <= 1'b0;
      sdaOeN      <= !(serState_q == mhc_pkg::S_ACK || (serState_q == mhc_pkg::S_RDATA && !serShift_q[7]));
      mgmtIrqOutN <= !(cfg_q[mhc_pkg::CFG_SMI_EN] && !cfg_q[mhc_pkg::CFG_INT_CLR] && smiAct);
      selIrqOut   <= cfg_q[mhc_pkg::CFG_NMI_POL] ? selAct : !selAct;
      bypassOut   <= 1'b0;
      bypassOeN   <= !cfg_q[mhc_pkg::CFG_BYPASS];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence seqStrobeHold;
    !strbLow ##1 strbLow [*2];
  endsequence
  sequence seqChipReset;
    chipRstWr ##1 fullRst_q;
  endsequence

  a_strobe_reset: assert property (seqStrobeHold |=> fullRst_q)
    else $error("strobe pattern did not reset");
  a_chip_reset: assert property (seqChipReset |=> slaveAddr_q == mhc_pkg::SADDR_RST)
    else $error("chip reset bit did not reset");
  a_soft_init: assert property (softInit && !fullRst_q |=> cfg_q == mhc_pkg::CFG_RST && isr1_q == 8'h00)
    else $error("soft init missed");
  a_addr_keep: assert property (softInit && !fullRst_q |=> $stable(slaveAddr_q))
    else $error("slave address lost on soft init");
  a_busy_flag: assert property (busy && isaCur.addr == mhc_pkg::PORT_INDEX |-> portRd[7])
    else $error("busy bit not shown");
  a_index_hold: assert property (isaDatRd && idx_q == mhc_pkg::A_CFG && !fullRst_q |=> idx_q == mhc_pkg::A_CFG)
    else $error("index moved");
  a_ptr_stop: assert property ((isaDatRd || isaDatWr) && idx_q == mhc_pkg::A_VAL_TOP && !fullRst_q |=> idx_q == mhc_pkg::A_VAL_TOP)
    else $error("pointer passed top");
  a_ser_noinc: assert property (serRegWr && !fullRst_q |=> $stable(idx_q))
    else $error("serial write moved pointer");
  a_ser_write: assert property (serRegWr && idx_q == mhc_pkg::A_SMI1 && !fullRst_q |=> smi1_q == $past(serShift_q))
    else $error("serial write not stored");
  a_read_restart: assert property (resultRd && run && monState_q == mhc_pkg::M_CONV && !fullRst_q |=> convStart)
    else $error("read did not restart conversion");
  a_halt_stop: assert property (!run |=> !convStart ##1 (run || !convStart))
    else $error("conversion while halted");
  a_int_clear: assert property (cfg_q[mhc_pkg::CFG_INT_CLR] |=> mgmtIrqOutN && selIrqOut != $past(cfg_q[5]))
    else $error("interrupt active under clear");
  a_irq_pol: assert property (selAct |=> selIrqOut == $past(cfg_q[mhc_pkg::CFG_NMI_POL]))
    else $error("interrupt polarity wrong");
  a_bypass_drv: assert property (cfg_q[mhc_pkg::CFG_BYPASS] |=> !bypassOeN && !bypassOut)
    else $error("bypass not driven");
endmodule : mhc_top

// ==== tb/mhc_ser_master.sv ====
// Serial bus master model driving SCL and SDA of the monitor block.
// Assumes SDA has a pull-up and is wired-AND outside; SCL stands high between frames.
`timescale 1ns/1ps
module mhc_ser_master (
  output logic      scl,
  output logic      sdaRel,
  input  wire logic sdaLine
);
  initial begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end
  task automatic bitx(input logic b, output logic s);
    sdaRel = b;
    #80 scl = 1'b1;
    #80 s = sdaLine;
    #80 scl = 1'b0;
    #80;
  endtask : bitx
  // Also serves as repeated start, since SCL is low between bytes
  task automatic start;
    sdaRel = 1'b1;
    #80 scl = 1'b1;
    #80 sdaRel = 1'b0;
    #80 scl = 1'b0;
    #80;
  endtask : start
  task automatic stop;
    sdaRel = 1'b0;
    #80 scl = 1'b1;
    #80 sdaRel = 1'b1;
    #80;
  endtask : stop
  // Ninth bit always released: sampled as ack on writes, left as nack on reads
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(1'b1, ack);
  endtask : xfer
  task automatic wr(input logic [6:0] sa, input logic [6:0] ptr, input logic [7:0] d, output logic ack);
    logic [7:0] x;
    logic       a0, a1, a2;
    start();
    xfer({sa, 1'b0}, x, a0);
    xfer({1'b0, ptr}, x, a1);
    xfer(d, x, a2);
    stop();
    ack = a0 | a1 | a2;
  endtask : wr
  task automatic rd(input logic [6:0] sa, input logic [6:0] ptr, input logic usePtr,
                    output logic [7:0] d, output logic ack);
    logic [7:0] x;
    logic       a0, a1;
    a1 = 1'b0;
    start();
    if (usePtr) begin
      xfer({sa, 1'b0}, x, a1);
      xfer({1'b0, ptr}, x, a0);
      start();
    end
    xfer({sa, 1'b1}, x, a0);
    ack = a0 | a1;
    xfer(8'hff, d, a0);
    stop();
  endtask : rd
endmodule : mhc_ser_master

// ==== tb/tb_top.sv ====
// Self-checking bench of the monitor host control block.
// Assumes a behavioural converter stub here and the serial master model beside it.
`timescale 1ns/1ps
module tb_top;
  logic       ref_clk, reset, isaCsN, isaRdN, isaWrN, isaDataOeN, sdaOut, sdaOeN, convDone, convStart;
  logic       mgmtIrqOutN, selIrqOut, bypassOut, bypassOeN, scl, sdaRel, a;
  logic [2:0] isaAddr;
  logic [7:0] isaDataIn, isaDataOut, convResult, d, r;
  logic [3:0] convChannel, expCh;
  logic [4:0] vidIn;
  logic [6:0] sa;
  int         mismatches, checks_done, cnt, doneCnt, w;
  wire logic  sdaLine = sdaRel & (sdaOeN | sdaOut);
  mhc_top #(.ROUND_CYCLES(400)) dut (.ref_clk, .reset, .isaCsN, .isaRdN, .isaWrN, .isaAddr, .isaDataIn,
    .isaDataOut, .isaDataOeN, .sclIn(scl), .sdaIn(sdaLine), .sdaOut, .sdaOeN, .vidIn, .eventIn1(8'h00),
    .eventIn2(8'h00), .convDone, .convResult, .convStart, .convChannel, .mgmtIrqOutN, .selIrqOut,
    .bypassOut, .bypassOeN);
  mhc_ser_master ser (.scl(scl), .sdaRel(sdaRel), .sdaLine(sdaLine));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Converter stub: answers each start three cycles later
  always @(posedge ref_clk) begin
    convDone <= 1'b0;
    if (cnt == 1) begin
      convDone <= 1'b1;
      convResult <= {4'ha, convChannel};
      doneCnt <= doneCnt + 1;
    end
    if (cnt != 0) cnt <= cnt - 1;
    if (convStart === 1'b1) begin
      cnt <= 3;
      if (doneCnt < 11) chk("channel", {4'h0, expCh}, {4'h0, convChannel});
      expCh <= (expCh == 4'ha) ? 4'h0 : expCh + 4'h1;
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic isa(input logic [2:0] ad, input logic wr, input logic [7:0] dw, output logic [7:0] dr);
    @(posedge ref_clk);
    isaCsN <= 1'b0;
    isaAddr <= ad;
    isaDataIn <= dw;
    isaWrN <= ~wr;
    isaRdN <= wr;
    cyc(5);
    #1 dr = isaDataOut;
    if (!wr) chk("data enable", 8'h00, {7'h0, isaDataOeN});
    @(posedge ref_clk);
    isaWrN <= 1'b1;
    isaRdN <= 1'b1;
    cyc(5);
    isaCsN <= 1'b1;
  endtask : isa
  task automatic wreg(input logic [6:0] ra, input logic [7:0] v);
    logic [7:0] x;
    isa(3'h5, 1'b1, {1'b0, ra}, x);
    isa(3'h6, 1'b1, v, x);
  endtask : wreg
  task automatic rreg(input logic [6:0] ra, output logic [7:0] v);
    isa(3'h5, 1'b1, {1'b0, ra}, v);
    isa(3'h6, 1'b0, 8'h00, v);
  endtask : rreg
  function automatic logic [7:0] rstv(input logic [6:0] ra);
    case (ra)
      mhc_pkg::A_CFG:    return mhc_pkg::CFG_RST;
      mhc_pkg::A_NMI2:   return mhc_pkg::NMI2_RST;
      mhc_pkg::A_FANDIV: return {mhc_pkg::FANDIV_RST, vidIn[3:0]};
      mhc_pkg::A_SADDR:  return {1'b0, sa};
      default:           return mhc_pkg::ZERO_RST;
    endcase
  endfunction : rstv
  task automatic chk_rst(input string n);
    logic [7:0] v;
    for (int i = 8'h40; i <= 8'h48; i++) begin
      rreg(7'(i), v);
      chk("reset value", rstv(7'(i)), v);
    end
    chk("irq idle", 8'h01, {7'h0, mgmtIrqOutN});
    $display("test %s done", n);
  endtask : chk_rst
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  initial begin
    {reset, isaCsN, isaRdN, isaWrN} = 4'hf;
    {isaAddr, isaDataIn, vidIn, cnt, doneCnt, expCh, sa} = '0;
    void'($urandom(5841));
    sa = mhc_pkg::SADDR_RST;
    vidIn = 5'($urandom);
    cyc(4);
    reset <= 1'b0;
    cyc(4);
    chk_rst("power on");
    d = 8'($urandom);
    wreg(7'h7e, d);
    isa(3'h6, 1'b1, d + 8'h01, r);
    isa(3'h6, 1'b1, d + 8'h02, r);
    isa(3'h5, 1'b0, 8'h00, r);
    chk("index", 8'h7f, r);
    rreg(7'h7e, r);
    chk("value", d, r);
    isa(3'h6, 1'b0, 8'h00, r);
    chk("value", d + 8'h02, r);
    isa(3'h6, 1'b0, 8'h00, r);
    chk("value", d + 8'h02, r);
    $display("test parallel done");
    ser.wr(sa, mhc_pkg::A_SMI1, d, a);
    chk("ack", 8'h00, {7'h0, a});
    ser.rd(sa, 7'h00, 1'b0, r, a);
    chk("serial read", d, r);
    isa(3'h5, 1'b0, 8'h00, r);
    chk("index", {1'b0, mhc_pkg::A_SMI1}, r);
    ser.rd(sa, mhc_pkg::A_SMI2, 1'b1, r, a);
    chk("serial read", 8'h00, {r[7:1], a});
    ser.wr(sa, mhc_pkg::A_SADDR, 8'h33, a);
    sa = 7'h33;
    wreg(mhc_pkg::A_CFG, 8'h80);
    chk_rst("soft init");
    $display("test serial done");
    wreg(mhc_pkg::A_CFG, 8'h60);
    cyc(4);
    chk("bypass", 8'h00, {6'h0, bypassOut, bypassOeN});
    chk("sel irq", 8'h00, {7'h0, selIrqOut});
    wreg(mhc_pkg::A_CFG, 8'h08);
    cyc(4);
    chk("sel irq", 8'h01, {7'h0, selIrqOut});
    for (int k = 0; k < 2; k++) begin
      if (k == 0) wreg(mhc_pkg::A_CHIPID, 8'h20);
      else begin
        isaRdN <= 1'b0;
        isaWrN <= 1'b0;
        cyc(4);
        isaRdN <= 1'b1;
        isaWrN <= 1'b1;
      end
      cyc(8);
      sa = mhc_pkg::SADDR_RST;
      chk_rst("full reset");
    end
    wreg(mhc_pkg::A_CFG, 8'h01);
    for (w = 0; w < 2000 && doneCnt < 11; w++) cyc(1);
    if (w == 2000) begin
      mismatches++;
      close_out();
    end
    wreg(mhc_pkg::A_CFG, 8'h00);
    for (int i = 0; i < 11; i++) begin
      rreg(7'h20 + 7'(i), r);
      chk("result", {4'ha, 4'(i)}, r);
    end
    $display("test monitor done");
    close_out();
  end
endmodule : tb_top
